//--- hdl/hbp_port.sv
/*
 Asynchronous host bus slave port: width and style pins, lane decode, handshake.
 Assumes host pins change freely; all logic runs on i_clk_sys, reset synchronous.
*/
`timescale 1ns/1ns
`include "hbp_regs.svh"

// Summary of operation
// - Wide mode maps data lines bit for bit.
// - Wide strobe style: low address names first byte.
// - Wide strobe style: size pins give byte count.
// - Wide enable style: A1,A0,S1,S0 are lane enables.
// - Wide reads always return the full word.
// - Narrow mode uses lower sixteen lines, mirrored.
// - Narrow mode: A1 selects upper or lower half.
// - Narrow mode: size pins enable byte lanes.
// - Read drives wait low and all data pins.
// - Finish: release wait, then ack or fault.
// - Strobe high drives ack and fault high.
// - Select high tristates; drive high first if early.
// - Enable style always gives ack, even with fault.
// - Writes store selected bytes into location.
// - Data memory and unused writes store nothing.
// - Data memory writes, invalid ranges give fault.
// - Lowest byte address is most significant byte.
// - Pins choose port width and bus style.
// - Without master clock every access faults.
module hbp_port #(
   parameter int CLK_TIMEOUT = `HBP_CLK_TIMEOUT_CYC,
   parameter int LOCAL_AW    = `HBP_LOCAL_AW
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_port_width_select,
   input  wire logic        i_bus_style_select,
   input  wire logic        i_master_clock_in,
   input  wire logic        i_chip_select_n,
   input  wire logic        i_cycle_strobe_n,
   input  wire logic        i_read_not_write,
   input  wire logic [18:0] i_addr,
   input  wire logic        i_xfer_size_bit1,
   input  wire logic        i_xfer_size_bit0,
   input  wire logic [31:0] i_data,
   output logic      [31:0] o_data,
   output logic             o_data_oe,
   output logic             o_wait_n,
   output logic             o_wait_oe,
   output logic             o_transfer_ack_n,
   output logic             o_bus_fault_n,
   output logic             o_ctl_oe
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]         cs_s;
      logic [1:0]         ds_s;
      logic [1:0]         rw_s;
      logic [2:0]         mclk_s;
      logic [15:0]        mclk_idle;
      hbp_pkg::hbp_state_t st;
      logic [1:0]         lat;
      hbp_pkg::hbp_req_t  req;
      hbp_pkg::hbp_pins_t pins;
   } hbp_port_state_t;

   hbp_port_state_t s;
   hbp_port_state_t next_s;
   logic [31:0]     rdata;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic [3:0] lane_decode(input logic wide, input logic style,
                                              input logic a1, input logic a0,
                                              input logic s1, input logic s0);
      logic [3:0] m;
      logic [2:0] cnt;
      m = 4'h0;
      cnt = 3'h0;
      if (!wide) begin
         m = {~s1, ~s0, ~s1, ~s0} & (a1 ? 4'h3 : 4'hC);
      end else if (style) begin
         m = {~a1, ~a0, ~s1, ~s0};
      end else begin
         unique case ({s1, s0})
            2'b00: cnt = 3'h4;
            2'b01: cnt = 3'h1;
            2'b10: cnt = 3'h2;
            2'b11: cnt = 3'h3;
         endcase
         for (int b = 0; b < 4; b++) begin
            // Byte index 0 is bits 31:24, so the lowest address is the MSB.
            if (b >= {a1, a0} && b < {a1, a0} + cnt) begin
               m[3 - b] = 1'b1;
            end
         end
      end
      return m;
   endfunction

   function automatic logic addr_invalid(input logic wr, input logic [18:0] a);
      logic dm;
      logic bad;
      dm  = (a >= `HBP_DATA_MEM_LO) && (a <= `HBP_DATA_MEM_HI);
      bad = ((a >= `HBP_INVALID_A_LO) && (a <= `HBP_INVALID_A_HI)) ||
            (a >= `HBP_INVALID_B_LO);
      return bad || (wr && dm);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        wide;
      logic [31:0] wd;
      logic        cs_act;
      logic        ds_act;
      wide   = ~i_port_width_select;
      wd     = wide ? i_data : {i_data[15:0], i_data[15:0]};
      cs_act = s.cs_s[1];
      ds_act = s.ds_s[1];
      next_s = s;
      // Only the second stage of the select, strobe and direction synchronisers is read below.
      next_s.cs_s   = {s.cs_s[0], ~i_chip_select_n};
      next_s.ds_s   = {s.ds_s[0], ~i_cycle_strobe_n};
      next_s.rw_s   = {s.rw_s[0], i_read_not_write};
      next_s.mclk_s = {s.mclk_s[1:0], i_master_clock_in};
      // A stalled master clock is seen as no edge for CLK_TIMEOUT cycles.
      if (s.mclk_s[2] != s.mclk_s[1]) begin
         next_s.mclk_idle = 16'h0;
      end else if (s.mclk_idle != 16'(CLK_TIMEOUT)) begin
         next_s.mclk_idle = s.mclk_idle + 16'h1;
      end
      if (s.lat != 2'h0) begin
         next_s.lat = s.lat - 2'h1;
      end
      unique case (s.st)
         hbp_pkg::HBP_IDLE: begin
            if (cs_act && ds_act) begin
               next_s.req.write   = ~s.rw_s[1];
               next_s.req.addr    = i_addr;
               next_s.req.lane_en = lane_decode(wide, i_bus_style_select, i_addr[1],
                                                i_addr[0], i_xfer_size_bit1,
                                                i_xfer_size_bit0);
               next_s.req.wdata   = wd;
               next_s.req.fault   = addr_invalid(~s.rw_s[1], i_addr) ||
                                    (s.mclk_idle == 16'(CLK_TIMEOUT));
               next_s.lat         = `HBP_MEM_LATENCY;
               next_s.pins.wait_n  = 1'b0;
               next_s.pins.wait_oe = 1'b1;
               next_s.pins.ack_n   = 1'b1;
               next_s.pins.fault_n = 1'b1;
               next_s.pins.ctl_oe  = 1'b1;
               next_s.pins.data_oe = s.rw_s[1];
               // A stale word from an earlier wide read must not show in narrow mode.
               next_s.pins.data    = 32'h0;
               next_s.st = hbp_pkg::HBP_ACCESS;
            end
         end
         hbp_pkg::HBP_ACCESS: begin
            if (s.lat == 2'h0) begin
               if (s.req.write) begin
                  next_s.pins.data = 32'h0;
               end else begin
                  // Full word on every wide read; narrow mode picks the half by A1.
                  next_s.pins.data = (wide) ? rdata :
                                     (s.req.addr[1] ? {16'h0, rdata[15:0]}
                                                    : {16'h0, rdata[31:16]});
               end
               next_s.pins.wait_n = 1'b1;
               next_s.st = hbp_pkg::HBP_ANSWER;
            end
         end
         hbp_pkg::HBP_ANSWER: begin
            // Wait rose last cycle; ack or fault follows one cycle later.
            next_s.pins.fault_n = ~s.req.fault;
            next_s.pins.ack_n   = s.req.fault && !i_bus_style_select;
            next_s.st = hbp_pkg::HBP_HOLD;
         end
         hbp_pkg::HBP_HOLD: begin
            if (!ds_act || !cs_act) begin
               next_s.pins.ack_n   = 1'b1;
               next_s.pins.fault_n = 1'b1;
               next_s.pins.wait_n  = 1'b1;
               next_s.st = hbp_pkg::HBP_DRAIN;
            end
         end
         hbp_pkg::HBP_DRAIN: begin
            // Lines are driven high for at least one cycle before release.
            if (!cs_act) begin
               next_s.pins.ctl_oe  = 1'b0;
               next_s.pins.wait_oe = 1'b0;
               next_s.pins.data_oe = 1'b0;
               next_s.st = hbp_pkg::HBP_IDLE;
            end
         end
         default: begin
            next_s.st = hbp_pkg::HBP_IDLE;
         end
      endcase
      if (i_reset) begin
         next_s = '0;
         next_s.pins.wait_n  = 1'b1;
         next_s.pins.ack_n   = 1'b1;
         next_s.pins.fault_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      s <= next_s;
   end

   // ----------------------------------------------------------------
   // Local store
   // ----------------------------------------------------------------
   hbp_store #(
      .AW (LOCAL_AW)
   ) u_store (
      .i_clk_sys (i_clk_sys),
      .i_addr    (s.req.addr[LOCAL_AW+1:2]),
      .i_wr      ((s.st == hbp_pkg::HBP_ACCESS) && (s.lat == 2'h1) && s.req.write &&
                  !s.req.fault),
      .i_lane_en (s.req.lane_en),
      .i_wdata   (s.req.wdata),
      .o_rdata   (rdata)
   );

   assign o_data           = s.pins.data;
   assign o_data_oe        = s.pins.data_oe;
   assign o_wait_n         = s.pins.wait_n;
   assign o_wait_oe        = s.pins.wait_oe;
   assign o_transfer_ack_n = s.pins.ack_n;
   assign o_bus_fault_n    = s.pins.fault_n;
   assign o_ctl_oe         = s.pins.ctl_oe;
endmodule // hbp_port

//--- hdl/hbp_store.sv
/*
 Small word memory standing in for the switch's registers and connection store.
 Assumes one clock; read data appear from a register one cycle after the request.
*/
`timescale 1ns/1ns
module hbp_store #(
   parameter int AW = 8
) (
   input  wire logic          i_clk_sys,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic          i_wr,
   input  wire logic [3:0]    i_lane_en,
   input  wire logic [31:0]   i_wdata,
   output logic      [31:0]   o_rdata
);
   logic [31:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_clk_sys) begin
      for (int b = 0; b < 4; b++) begin
         if (i_wr && i_lane_en[b]) begin
            mem[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8];
         end
      end
      o_rdata <= mem[i_addr];
   end
endmodule // hbp_store

//--- shared/hbp_pkg.sv
/*
 Types used by the host bus port for its state, request and pins.
 Assumes the constants header is on the include path.
*/
package hbp_pkg;

   typedef enum logic [2:0] {
      HBP_IDLE   = 3'b000,
      HBP_ACCESS = 3'b001,
      HBP_ANSWER = 3'b011,
      HBP_HOLD   = 3'b010,
      HBP_DRAIN  = 3'b110
   } hbp_state_t;

   typedef struct packed {
      logic        write;
      logic [18:0] addr;
      logic [3:0]  lane_en;
      logic [31:0] wdata;
      logic        fault;
   } hbp_req_t;

   typedef struct packed {
      logic        wait_n;
      logic        wait_oe;
      logic        ack_n;
      logic        fault_n;
      logic        ctl_oe;
      logic [31:0] data;
      logic        data_oe;
   } hbp_pins_t;

endpackage

//--- shared/hbp_regs.svh
/*
 Timing counts, address-map bounds and address widths for the host bus port.
 Assumes inclusion by the host bus port design file only.
*/
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH

// ----------------------------------------------------------------
// Address map, word-granular boundaries (byte address bits 18:0)
// ----------------------------------------------------------------
`define HBP_DATA_MEM_LO      19'h28000
`define HBP_DATA_MEM_HI      19'h2FFFF
`define HBP_INVALID_A_LO    19'h38000
`define HBP_INVALID_A_HI    19'h3FFFF
`define HBP_INVALID_B_LO    19'h40290
`define HBP_ADDR_W          19
`define HBP_LOCAL_AW        8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBP_CLK_PERIOD_NS   10
`define HBP_CLK_TIMEOUT_NS  2000
`define HBP_CLK_TIMEOUT_CYC (`HBP_CLK_TIMEOUT_NS / `HBP_CLK_PERIOD_NS)
`define HBP_MEM_LATENCY     2'h2

`endif

//--- tb/hbp_host.sv
/*
 Host processor model driving chip select directly, one access per call.
 Assumes pins move only on falling clock edges.
*/
`timescale 1ns/1ns
module hbp_host (
   input  wire logic        i_clk_sys,
   input  wire logic [31:0] i_rd,
   input  wire logic        i_ack_n,
   input  wire logic        i_flt_n,
   output logic             o_cs_n,
   output logic             o_ds_n,
   output logic             o_rnw,
   output logic [18:0]      o_addr,
   output logic [1:0]       o_size,
   output logic [31:0]      o_wd
);
   // Set by the bench to raise chip select one cycle before the strobe.
   logic early_cs = 1'b0;
   initial begin
      o_cs_n = 1'b1;
      o_ds_n = 1'b1;
      o_rnw = 1'b1;
      o_addr = 19'h00000;
      o_size = 2'h0;
      o_wd = 32'h00000000;
   end
   task automatic access(input logic rnw, input logic [18:0] a, input logic [1:0] sz,
                         input logic [31:0] wd, output logic [31:0] rd,
                         output logic ack, output logic flt, output logic ok);
      ok = 1'b0;
      @(negedge i_clk_sys);
      o_rnw = rnw;
      o_addr = a;
      o_size = sz;
      o_cs_n = 1'b0;
      // Lines not driven on a read show a changing pattern, never the last value.
      o_wd = rnw ? ~o_wd : wd;
      @(negedge i_clk_sys);
      o_ds_n = 1'b0;
      for (int n = 0; n < 20 && !ok; n++) begin
         @(posedge i_clk_sys);
         if (i_ack_n === 1'b0 || i_flt_n === 1'b0) begin
            ok = 1'b1;
            ack = !i_ack_n;
            flt = !i_flt_n;
            rd = i_rd;
         end
      end
      @(negedge i_clk_sys);
      if (early_cs) begin
         o_cs_n = 1'b1;
         @(negedge i_clk_sys);
      end
      o_ds_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      o_cs_n = 1'b1;
      repeat (5) @(negedge i_clk_sys);
   endtask
endmodule // hbp_host

//--- tb/hbp_port_assertions.sv
/*
 Checker for the host bus port handshake, bound to every hbp_port.
 Assumes a single clock domain and the synchronous reset of the port.
*/
`timescale 1ns/1ns
module hbp_port_assertions #(
   parameter int CLK_TIMEOUT = 8
) (
   input wire logic        i_clk_sys,
   input wire logic        i_reset,
   input wire logic        i_port_width_select,
   input wire logic        i_bus_style_select,
   input wire logic        i_chip_select_n,
   input wire logic        i_cycle_strobe_n,
   input wire logic [31:0] o_data,
   input wire logic        o_data_oe,
   input wire logic        o_wait_n,
   input wire logic        o_wait_oe,
   input wire logic        o_transfer_ack_n,
   input wire logic        o_bus_fault_n,
   input wire logic        o_ctl_oe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   property p_wait; $fell(o_wait_n) |-> o_wait_oe && o_ctl_oe && o_transfer_ack_n && o_bus_fault_n;
   endproperty
   property p_sync; $fell(o_wait_n) |-> !$past(i_chip_select_n, 2) && !$past(i_cycle_strobe_n, 2);
   endproperty
   property p_done; $fell(o_transfer_ack_n) || $fell(o_bus_fault_n) |-> o_wait_n && $past(o_wait_n);
   endproperty
   property p_release; $rose(i_cycle_strobe_n) |-> ##[1:5] (o_transfer_ack_n && o_bus_fault_n);
   endproperty
   property p_float; $rose(i_chip_select_n) |-> ##[1:6] !(o_ctl_oe || o_wait_oe || o_data_oe);
   endproperty
   property p_high_first;
      $fell(o_ctl_oe) |-> $past(o_transfer_ack_n) && $past(o_bus_fault_n) && $past(o_wait_n);
   endproperty
   property p_enable_ack; i_bus_style_select && $fell(o_bus_fault_n) |-> !o_transfer_ack_n;
   endproperty
   property p_strobe_fault; !i_bus_style_select && $fell(o_bus_fault_n) |-> o_transfer_ack_n;
   endproperty
   property p_narrow; i_port_width_select && o_data_oe |-> o_data[31:16] == 16'h0000;
   endproperty
   a_wait: assert property (p_wait) else $error("wait fell out of turn");
   a_sync: assert property (p_sync) else $error("access began too early");
   a_done: assert property (p_done) else $error("answer before wait release");
   a_release: assert property (p_release) else $error("answer not withdrawn");
   a_float: assert property (p_float) else $error("pins not released");
   a_high_first: assert property (p_high_first) else $error("released while low");
   a_enable_ack: assert property (p_enable_ack) else $error("fault without ack");
   a_strobe_fault: assert property (p_strobe_fault) else $error("ack with fault");
   a_narrow: assert property (p_narrow) else $error("upper lines driven");
   c_fault: cover property ($fell(o_bus_fault_n));
   c_ack: cover property ($fell(o_transfer_ack_n));
   c_narrow: cover property (i_port_width_select && o_data_oe);
endmodule // hbp_port_assertions
bind hbp_port hbp_port_assertions #(.CLK_TIMEOUT(CLK_TIMEOUT)) u_hbp_port_assertions (
   .i_clk_sys, .i_reset, .i_port_width_select, .i_bus_style_select, .i_chip_select_n,
   .i_cycle_strobe_n, .o_data, .o_data_oe, .o_wait_n, .o_wait_oe, .o_transfer_ack_n,
   .o_bus_fault_n, .o_ctl_oe);

//--- tb/hbp_port_bench.sv
/*
 Self-checking bench for the host bus port.
 Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module hbp_port_bench;
   logic clk = 1'b0, rst = 1'b1, wsel = 1'b0, ssel = 1'b0, mck = 1'b0, run = 1'b1;
   logic cs_n, ds_n, rnw, doe, woe, wn, ack_n, flt_n, coe;
   logic [18:0] addr;
   logic [1:0]  size;
   logic [31:0] wd, rd;
   int          mismatches = 0, checked = 0;
   always #5 clk = ~clk;
   always @(negedge clk) if (run) mck <= ~mck;
   hbp_host u_hbp_host (.i_clk_sys(clk), .i_rd(rd), .i_ack_n(ack_n), .i_flt_n(flt_n),
      .o_cs_n(cs_n), .o_ds_n(ds_n), .o_rnw(rnw), .o_addr(addr), .o_size(size), .o_wd(wd));
   hbp_port #(.CLK_TIMEOUT(8)) u_hbp_port (.i_clk_sys(clk), .i_reset(rst),
      .i_port_width_select(wsel), .i_bus_style_select(ssel), .i_master_clock_in(mck),
      .i_chip_select_n(cs_n), .i_cycle_strobe_n(ds_n), .i_read_not_write(rnw), .i_addr(addr),
      .i_xfer_size_bit1(size[1]), .i_xfer_size_bit0(size[0]), .i_data(wd), .o_data(rd),
      .o_data_oe(doe), .o_wait_n(wn), .o_wait_oe(woe), .o_transfer_ack_n(ack_n),
      .o_bus_fault_n(flt_n), .o_ctl_oe(coe));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data are judged only when the access is expected to succeed.
   task automatic xfer(input logic r, input logic [18:0] a, input logic [1:0] sz,
                       input logic [31:0] d, input logic ea, input logic ef);
      logic [31:0] got;
      logic        ack, flt, ok;
      u_hbp_host.access(r, a, sz, d, got, ack, flt, ok);
      chk("handshake", {31'h0, ok}, 32'h1);
      if (!ok) end_of_test();
      chk("ack", {31'h0, ack}, {31'h0, ea});
      chk("fault", {31'h0, flt}, {31'h0, ef});
      if (r && ea && !ef) chk("read data", got, d);
      chk("released enables", {29'h0, doe, woe, coe}, 32'h0);
      chk("idle levels", {29'h0, wn, ack_n, flt_n}, 32'h7);
   endtask
   task t_wide;
      xfer(0, 19'h00010, 2'h0, 32'h11223344, 1, 0);
      xfer(1, 19'h00013, 2'h1, 32'h11223344, 1, 0);
      xfer(0, 19'h00012, 2'h1, 32'hAABBCCDD, 1, 0);
      xfer(0, 19'h00011, 2'h2, 32'h55667788, 1, 0);
      xfer(1, 19'h00010, 2'h0, 32'h11667744, 1, 0);
      xfer(0, 19'h00011, 2'h3, 32'h0A0B0C0D, 1, 0);
      xfer(1, 19'h00010, 2'h0, 32'h110B0C0D, 1, 0);
      u_hbp_host.early_cs = 1'b1;
      xfer(1, 19'h00010, 2'h0, 32'h110B0C0D, 1, 0);
      u_hbp_host.early_cs = 1'b0;
      $display("test wide done");
   endtask
   task t_enable;
      ssel = 1'b1;
      xfer(0, 19'h00011, 2'h2, 32'hF0E1D2C3, 1, 0);
      xfer(1, 19'h00010, 2'h0, 32'hF00B0CC3, 1, 0);
      xfer(0, 19'h28010, 2'h0, 32'h00000000, 1, 1);
      xfer(1, 19'h00010, 2'h0, 32'hF00B0CC3, 1, 0);
      ssel = 1'b0;
      $display("test enable done");
   endtask
   task t_fault;
      xfer(1, 19'h28010, 2'h0, 32'hF00B0CC3, 1, 0);
      xfer(0, 19'h28010, 2'h0, 32'h00000000, 0, 1);
      xfer(1, 19'h38000, 2'h0, 32'h00000000, 0, 1);
      xfer(0, 19'h40290, 2'h0, 32'h00000000, 0, 1);
      xfer(1, 19'h00010, 2'h0, 32'hF00B0CC3, 1, 0);
      $display("test fault done");
   endtask
   task t_narrow;
      wsel = 1'b1;
      xfer(0, 19'h00012, 2'h0, 32'h0000BEEF, 1, 0);
      xfer(1, 19'h00012, 2'h0, 32'h0000BEEF, 1, 0);
      xfer(1, 19'h00010, 2'h0, 32'h0000F00B, 1, 0);
      xfer(0, 19'h00010, 2'h1, 32'h00005A00, 1, 0);
      xfer(0, 19'h00010, 2'h3, 32'h00001234, 1, 0);
      ssel = 1'b1;
      xfer(0, 19'h00010, 2'h2, 32'h00000077, 1, 0);
      xfer(1, 19'h00010, 2'h0, 32'h00005A77, 1, 0);
      ssel = 1'b0;
      wsel = 1'b0;
      $display("test narrow done");
   endtask
   task t_noclk;
      run = 1'b0;
      repeat (12) @(negedge clk);
      xfer(1, 19'h00010, 2'h0, 32'h00000000, 0, 1);
      run = 1'b1;
      repeat (12) @(negedge clk);
      xfer(1, 19'h00010, 2'h0, 32'h5A77BEEF, 1, 0);
      $display("test no clock done");
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_wide();
      t_enable();
      t_fault();
      t_narrow();
      t_noclk();
      end_of_test();
   end
endmodule // hbp_port_bench
